/* File: test/dtu_crt_monitor.sv */
// Model of the monitor at the sync pins
`timescale 1ns/100ps
module dtu_crt_monitor (
  input  wire logic sys_clk,
  input  wire logic hsync,
  input  wire logic vsync,
  output int        h_high,
  output int        h_period,
  output int        v_high,
  output int        h_rises
);
  int   hc, pc, vc;
  logic h_q = 1'b0;
  logic v_q = 1'b0;
  // ----
  // Pulse and period counters
  // ----
  always @(posedge sys_clk) begin
    pc = pc + 1;
    if (hsync && !h_q) begin
      h_period <= pc;
      h_rises  <= h_rises + 1;
      pc = 0;
    end
    if (!hsync && h_q) h_high <= hc;
    if (!vsync && v_q) v_high <= vc;
    hc = hsync ? hc + 1 : 0;
    vc = vsync ? vc + 1 : 0;
    h_q = hsync;
    v_q = vsync;
  end
endmodule

/* File: test/dtu_timing_properties.sv */
// Port checker for the display timing unit
`timescale 1ns/100ps
module dtu_checker (
  input wire logic                       sys_clk,
  input wire logic                       rst_n,
  input wire logic [7:0]                 reg_addr,
  input wire logic [7:0]                 reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [7:0]                 reg_rdata,
  input wire logic                       hsync_neg_sel,
  input wire logic                       vsync_neg_sel,
  input wire logic                       hsync,
  input wire logic                       vsync,
  input wire logic                       mem_fetch,
  input wire logic [dtu_pkg::ADDR_W-1:0] mem_addr
);
  // ----
  // Shadow of the mode bits
  // ----
  logic       rd_q, en, frc, byt, dw, s_ok;
  logic [7:0] ra_q;
  logic [5:0] cfg, st1, st2;
  assign cfg  = {en, frc, hsync_neg_sel, vsync_neg_sel, byt, dw};
  assign s_ok = (cfg == st1) && (st1 == st2);
  always_ff @(posedge sys_clk) begin
    rd_q <= rst_n && reg_rd;
    ra_q <= reg_addr;
    st1  <= cfg;
    st2  <= st1;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      {en, frc, byt, dw} <= 4'h0;
    end else if (reg_wr) begin
      if (reg_addr == dtu_pkg::IDX_MODE) {en, byt} <= reg_wdata[7:6];
      if (reg_addr == dtu_pkg::IDX_UNDERLINE) dw <= reg_wdata[6];
      if (reg_addr == dtu_pkg::IDX_TEST) frc <= reg_wdata[0];
    end
  end
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_rdata_gap: assert property (!rd_q |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_ul_resv: assert property (rd_q && ra_q == dtu_pkg::IDX_UNDERLINE |-> !reg_rdata[7])
    else $error("underline reserved bit set");
  a_mode_resv: assert property (rd_q && ra_q == dtu_pkg::IDX_MODE |-> (reg_rdata & 8'h33) == 8'h00)
    else $error("mode reserved bits set");
  a_test_resv: assert property (rd_q && ra_q == dtu_pkg::IDX_TEST |-> (reg_rdata & 8'h0e) == 8'h00)
    else $error("test reserved bits set");
  a_sync_off: assert property (s_ok && !cfg[5] |-> hsync == (cfg[3] && !cfg[4]) && vsync == (cfg[2] && !cfg[4]))
    else $error("sync pulse while disabled");
  a_fetch_gap: assert property (mem_fetch |=> !mem_fetch [*7])
    else $error("fetch closer than a character");
  a_addr_word: assert property (s_ok && !cfg[1] && !cfg[0] |-> !mem_addr[0])
    else $error("word address not shifted");
  a_addr_dword: assert property (s_ok && cfg[0] |-> mem_addr[1:0] == 2'h0)
    else $error("doubleword address not shifted");
endmodule
bind dtu_timing dtu_checker u_dtu_checker (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hsync_neg_sel(hsync_neg_sel),
  .vsync_neg_sel(vsync_neg_sel), .hsync(hsync), .vsync(vsync), .mem_fetch(mem_fetch), .mem_addr(mem_addr));

/* File: test/dtu_timing_tb.sv */
// Self-checking bench for the display timing unit
`timescale 1ns/100ps
module dtu_timing_tb;
  logic        sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        hsync_neg_sel = 1'b0, vsync_neg_sel = 1'b0, hsync, vsync, mem_fetch;
  logic        underline_scan, display_active, vblank;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, host_latch_data = 8'h00, reg_rdata;
  logic [15:0] mem_addr, f0, f4, pf0, pf4;
  int          fails, compares, cyc, t_rel, lines, fi, h_high, h_period, v_high, h_rises;
  time         lt;
  logic [7:0]  idx [11] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h22, 8'h26, 8'h2f, 8'h30};
  logic [7:0]  msk [11] = '{8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hcc, 8'hff, 8'h00, 8'hff, 8'hf1, 8'h00};
  logic [7:0]  ul [5] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h20};
  logic [7:0]  md [5] = '{8'h00, 8'h40, 8'h00, 8'h08, 8'h00};
  int          sc [5] = '{4, 2, 8, 4, 4};
  int          s4 [5] = '{8, 4, 16, 4, 2};
  dtu_timing u_dtu_timing (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_latch_data(host_latch_data),
    .hsync_neg_sel(hsync_neg_sel), .vsync_neg_sel(vsync_neg_sel), .hsync(hsync), .vsync(vsync),
    .display_active(display_active), .vblank(vblank), .underline_scan(underline_scan), .mem_fetch(mem_fetch),
    .mem_addr(mem_addr));
  dtu_crt_monitor u_dtu_crt_monitor (.sys_clk(sys_clk), .hsync(hsync), .vsync(vsync), .h_high(h_high),
    .h_period(h_period), .v_high(v_high), .h_rises(h_rises));
  // ----
  // Clock, timeout and fetch tracker
  // ----
  initial forever #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 80000) begin
      fails++;
      final_report;
    end
  end
  always @(posedge sys_clk) begin
    if (mem_fetch === 1'b1) begin
      if ($time - lt > 200) begin
        pf0 = f0;
        pf4 = f4;
        f0 = mem_addr;
        fi = 0;
        lines++;
      end else fi++;
      if (fi == 4) f4 = mem_addr;
      lt = $time;
    end
  end
  // ----
  // Tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reset_dut;
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_rel = cyc;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    q = reg_rdata;
  endtask
  task automatic wrise(input int k);
    int n;
    repeat (k) begin
      n = h_rises;
      while (h_rises == n) @(posedge sys_clk);
    end
  endtask
  task automatic final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    logic [7:0] v, d;
    int         n, p, u;
    int         tv [3] = '{8'h00, 8'h10, 8'h20};
    int         nr [3] = '{0, 3, 1};
    void'($urandom(32'h92f610f3));
    reset_dut;
    for (int i = 0; i < 11; i++) begin
      host_latch_data <= 8'($urandom);
      rd(idx[i], v);
      check(v, i == 7 ? host_latch_data : 8'h00);
      d = 8'($urandom);
      wr(idx[i], d);
      rd(idx[i], v);
      check(v, i == 7 ? host_latch_data : d & msk[i]);
    end
    reset_dut;
    wr(8'h12, 8'hff);
    u = $urandom_range(7);
    wr(8'h14, 8'(u));
    repeat (2) @(posedge sys_clk);
    while (!underline_scan) @(posedge sys_clk);
    check((cyc - t_rel) / 800, u);
    check({display_active, vblank}, {1'b1, u != 0});
    for (int i = 0; i < 5; i++) begin
      p = $urandom_range(255, 1);
      wr(8'h13, 8'(p));
      wr(8'h14, ul[i]);
      wr(8'h17, md[i]);
      n = lines;
      while (lines < n + 3) @(posedge sys_clk);
      check(16'(f0 - pf0), 16'(p * sc[i]));
      check(16'(pf4 - pf0), 16'(s4[i]));
    end
    reset_dut;
    wr(8'h17, 8'h84);
    wr(8'h2f, 8'h40);
    repeat (7) rd(8'h30, v);
    wr(8'h2f, 8'h80);
    rd(8'h30, v);
    wr(8'h2f, 8'h00);
    while (!vsync) @(posedge sys_clk);
    check((cyc - t_rel) / 800, 20);
    while (vsync) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    check(v_high, 3200);
    for (int i = 0; i < 3; i++) begin
      wr(8'(tv[i]), 8'h00);
      wr(8'h2f, 8'(tv[i]));
      wrise(1);
      repeat (208) @(posedge sys_clk);
      repeat (nr[i]) begin
        rd(8'h30, v);
        repeat (6) @(posedge sys_clk);
      end
      wrise(1);
      check(h_period, 800 - 8 * nr[i] * (i == 2 ? 16 : 1));
      check(h_high, 96);
    end
    wr(8'h2f, 8'h00);
    hsync_neg_sel <= 1'b1;
    vsync_neg_sel <= 1'b1;
    wrise(3);
    check(h_high, 704);
    wr(8'h2f, 8'h01);
    wrise(3);
    check(h_high, 96);
    wr(8'h2f, 8'h00);
    hsync_neg_sel <= 1'b0;
    vsync_neg_sel <= 1'b0;
    wr(8'h17, 8'h00);
    repeat (4) @(posedge sys_clk);
    n = h_rises;
    repeat (1700) @(posedge sys_clk);
    check(h_rises, n);
    final_report;
  end
endmodule

/* File: verilog/dtu_char_clock.sv */
// Character clock enable divider
`timescale 1ns/100ps
module dtu_char_clock (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  output logic      char_en
);

  logic [3:0] div_cnt;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_cnt <= 4'h0;
    end else if (div_cnt == dtu_pkg::CHAR_DIV_LAST) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  assign char_en = (div_cnt == dtu_pkg::CHAR_DIV_LAST);

endmodule

/* File: verilog/dtu_fetch_addr.sv */
// Display memory fetch address generator
`timescale 1ns/100ps
module dtu_fetch_addr (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      char_en,
  input  wire logic                      h_active,
  input  wire logic                      line_wrap,
  input  wire logic                      line_adv,
  input  wire logic                      frame_wrap,
  input  wire logic [7:0]                pitch,
  input  wire dtu_pkg::dtu_fetch_e       fetch_mode,
  input  wire dtu_pkg::dtu_step_e        step_mode,
  output logic      [dtu_pkg::ADDR_W-1:0] mem_addr
);

  logic [dtu_pkg::ADDR_W-1:0] line_start;
  logic [dtu_pkg::ADDR_W-1:0] addr_cnt;
  logic [dtu_pkg::ADDR_W-1:0] pitch_step;
  logic [1:0]                 sub_cnt;
  logic                       step_tick;

  // ----------------------------------------------------------------
  // Pitch scaling
  // ----------------------------------------------------------------
  // Counter units; the output shift completes x4 and x8
  assign pitch_step = {7'h00, pitch, 1'b0};

  // ----------------------------------------------------------------
  // Step divider
  // ----------------------------------------------------------------
  always_comb begin
    unique case (step_mode)
      dtu_pkg::STEP_1: step_tick = 1'b1;
      dtu_pkg::STEP_2: step_tick = sub_cnt[0];
      dtu_pkg::STEP_4: step_tick = (sub_cnt == 2'h3);
      default:         step_tick = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || line_wrap) begin
      sub_cnt <= 2'h0;
    end else if (char_en && h_active) begin
      sub_cnt <= sub_cnt + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Line start and address counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n || frame_wrap) begin
      line_start <= '0;
    end else if (line_adv) begin
      line_start <= line_start + pitch_step;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addr_cnt <= '0;
    end else if (line_wrap) begin
      addr_cnt <= frame_wrap ? '0 : (line_adv ? line_start + pitch_step : line_start);
    end else if (char_en && h_active && step_tick) begin
      addr_cnt <= addr_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Output address
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mem_addr <= '0;
    end else begin
      unique case (fetch_mode)
        dtu_pkg::FETCH_BYTE:  mem_addr <= addr_cnt;
        dtu_pkg::FETCH_WORD:  mem_addr <= {addr_cnt[14:0], 1'b0};
        dtu_pkg::FETCH_DWORD: mem_addr <= {addr_cnt[13:0], 2'h0};
        default:              mem_addr <= addr_cnt;
      endcase
    end
  end

endmodule

/* File: verilog/dtu_pkg.sv */
// Constants, field positions and encodings of the display timing unit
package dtu_pkg;

  // ----------------------------------------------------------------
  // Register indexes
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_VACT_END     = 8'h12;
  localparam logic [7:0] IDX_PITCH        = 8'h13;
  localparam logic [7:0] IDX_UNDERLINE    = 8'h14;
  localparam logic [7:0] IDX_VBLANK_START = 8'h15;
  localparam logic [7:0] IDX_VBLANK_END   = 8'h16;
  localparam logic [7:0] IDX_MODE         = 8'h17;
  localparam logic [7:0] IDX_SPLIT        = 8'h18;
  localparam logic [7:0] IDX_HOST_LATCH   = 8'h22;
  localparam logic [7:0] IDX_ATTR         = 8'h26;
  localparam logic [7:0] IDX_TEST         = 8'h2f;

  // ----------------------------------------------------------------
  // Field positions, write masks and reset values
  // ----------------------------------------------------------------
  localparam int UL_DWORD_BIT     = 6;
  localparam int UL_COUNT4_BIT    = 5;
  localparam int UL_LOC_MSB       = 4;
  localparam int MODE_SYNC_EN_BIT = 7;
  localparam int MODE_BYTE_BIT    = 6;
  localparam int MODE_COUNT2_BIT  = 3;
  localparam int MODE_VDOUBLE_BIT = 2;
  localparam int TEST_V5_BIT      = 7;
  localparam int TEST_V4_BIT      = 6;
  localparam int TEST_H5_BIT      = 5;
  localparam int TEST_H4_BIT      = 4;
  localparam int TEST_FORCE_BIT   = 0;

  localparam logic [7:0] UL_WRITE_MASK   = 8'h7f;
  localparam logic [7:0] MODE_WRITE_MASK = 8'hcc;
  localparam logic [7:0] TEST_WRITE_MASK = 8'hf1;
  localparam logic [7:0] REG_RESET       = 8'h00;

  // ----------------------------------------------------------------
  // Counter widths and fixed timing
  // ----------------------------------------------------------------
  localparam int HCNT_W = 9;
  localparam int VCNT_W = 10;
  localparam int ADDR_W = 16;

  localparam logic [3:0]        CHAR_DIV_LAST = 4'h7;
  localparam logic [HCNT_W-1:0] H_TOTAL       = 9'h063;
  localparam logic [HCNT_W-1:0] H_ACTIVE      = 9'h050;
  localparam logic [HCNT_W-1:0] H_SYNC_START  = 9'h054;
  localparam logic [HCNT_W-1:0] H_SYNC_END    = 9'h060;
  localparam logic [VCNT_W-1:0] V_TOTAL       = 10'h20c;
  localparam logic [VCNT_W-1:0] V_SYNC_START  = 10'h1ea;
  localparam logic [VCNT_W-1:0] V_SYNC_END    = 10'h1ec;
  localparam logic [4:0]        ROW_LAST      = 5'h0f;

  // Lowest bit of each test-clocked counter section
  localparam int V5_LSB = 5;
  localparam int V4_LSB = 6;
  localparam int H5_LSB = 4;
  localparam int H4_LSB = 0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FETCH_BYTE  = 3'h1,
    FETCH_WORD  = 3'h2,
    FETCH_DWORD = 3'h4
  } dtu_fetch_e;

  typedef enum logic [2:0] {
    STEP_1 = 3'h1,
    STEP_2 = 3'h2,
    STEP_4 = 3'h4
  } dtu_step_e;

endpackage

/* File: verilog/dtu_timing.sv */
// Display timing unit: indexed registers, counters, sync and fetch address
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
module dtu_timing (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [7:0]                 reg_rdata,
  input  wire logic [7:0]                 host_latch_data,
  input  wire logic                       hsync_neg_sel,
  input  wire logic                       vsync_neg_sel,
  output logic                            hsync,
  output logic                            vsync,
  output logic                            display_active,
  output logic                            vblank,
  output logic                            underline_scan,
  output logic                            mem_fetch,
  output logic      [dtu_pkg::ADDR_W-1:0] mem_addr
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]                 vertical_active_end;
  logic [7:0]                 line_pitch;
  logic [7:0]                 underline_row_register;
  logic [7:0]                 vertical_blanking_start;
  logic [7:0]                 vertical_blanking_end;
  logic [7:0]                 timing_mode_control;
  logic [7:0]                 split_screen_line;
  logic [7:0]                 attribute_access;
  logic [7:0]                 timing_test_control;

  logic [dtu_pkg::HCNT_W-1:0] h_cnt;
  logic [dtu_pkg::VCNT_W-1:0] v_cnt;
  logic [dtu_pkg::HCNT_W-1:0] h_test_inc;
  logic [dtu_pkg::VCNT_W-1:0] v_test_inc;
  logic [4:0]                 row_scan;
  logic                       half_line;
  logic                       char_en;
  logic                       line_wrap;
  logic                       line_adv;
  logic                       frame_wrap;
  logic                       test_read;
  logic                       h_active;
  logic                       h_sync_win;
  logic                       v_sync_win;
  logic                       sync_en;
  logic                       h_act_lvl;
  logic                       v_act_lvl;
  logic [7:0]                 next_rdata;
  dtu_pkg::dtu_fetch_e        fetch_mode;
  dtu_pkg::dtu_step_e         step_mode;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vertical_active_end     <= dtu_pkg::REG_RESET;
      line_pitch              <= dtu_pkg::REG_RESET;
      vertical_blanking_start <= dtu_pkg::REG_RESET;
      vertical_blanking_end   <= dtu_pkg::REG_RESET;
      split_screen_line       <= dtu_pkg::REG_RESET;
      attribute_access        <= dtu_pkg::REG_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        dtu_pkg::IDX_VACT_END:     vertical_active_end     <= reg_wdata;
        dtu_pkg::IDX_PITCH:        line_pitch              <= reg_wdata;
        dtu_pkg::IDX_VBLANK_START: vertical_blanking_start <= reg_wdata;
        dtu_pkg::IDX_VBLANK_END:   vertical_blanking_end   <= reg_wdata;
        dtu_pkg::IDX_SPLIT:        split_screen_line       <= reg_wdata;
        dtu_pkg::IDX_ATTR:         attribute_access        <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      underline_row_register <= dtu_pkg::REG_RESET;
    end else if (reg_wr && reg_addr == dtu_pkg::IDX_UNDERLINE) begin
      underline_row_register <= reg_wdata & dtu_pkg::UL_WRITE_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      timing_mode_control <= dtu_pkg::REG_RESET;
    end else if (reg_wr && reg_addr == dtu_pkg::IDX_MODE) begin
      timing_mode_control <= reg_wdata & dtu_pkg::MODE_WRITE_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      timing_test_control <= dtu_pkg::REG_RESET;
    end else if (reg_wr && reg_addr == dtu_pkg::IDX_TEST) begin
      timing_test_control <= reg_wdata & dtu_pkg::TEST_WRITE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb begin
    unique case (reg_addr)
      dtu_pkg::IDX_VACT_END:     next_rdata = vertical_active_end;
      dtu_pkg::IDX_PITCH:        next_rdata = line_pitch;
      dtu_pkg::IDX_UNDERLINE:    next_rdata = underline_row_register;
      dtu_pkg::IDX_VBLANK_START: next_rdata = vertical_blanking_start;
      dtu_pkg::IDX_VBLANK_END:   next_rdata = vertical_blanking_end;
      dtu_pkg::IDX_MODE:         next_rdata = timing_mode_control;
      dtu_pkg::IDX_SPLIT:        next_rdata = split_screen_line;
      dtu_pkg::IDX_HOST_LATCH:   next_rdata = host_latch_data;
      dtu_pkg::IDX_ATTR:         next_rdata = attribute_access;
      dtu_pkg::IDX_TEST:         next_rdata = timing_test_control;
      default:                   next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    if (underline_row_register[dtu_pkg::UL_DWORD_BIT]) begin
      fetch_mode = dtu_pkg::FETCH_DWORD;
    end else if (timing_mode_control[dtu_pkg::MODE_BYTE_BIT]) begin
      fetch_mode = dtu_pkg::FETCH_BYTE;
    end else begin
      fetch_mode = dtu_pkg::FETCH_WORD;
    end
  end

  always_comb begin
    if (underline_row_register[dtu_pkg::UL_COUNT4_BIT]) begin
      step_mode = dtu_pkg::STEP_4;
    end else if (timing_mode_control[dtu_pkg::MODE_COUNT2_BIT]) begin
      step_mode = dtu_pkg::STEP_2;
    end else begin
      step_mode = dtu_pkg::STEP_1;
    end
  end

  // ----------------------------------------------------------------
  // Test clocking of counter sections
  // ----------------------------------------------------------------
  assign test_read = reg_rd && (timing_test_control[dtu_pkg::TEST_V5_BIT:dtu_pkg::TEST_H4_BIT] != 4'h0);

  always_comb begin
    h_test_inc = '0;
    v_test_inc = '0;
    if (timing_test_control[dtu_pkg::TEST_H5_BIT]) begin
      h_test_inc[dtu_pkg::H5_LSB] = 1'b1;
    end
    if (timing_test_control[dtu_pkg::TEST_H4_BIT]) begin
      h_test_inc[dtu_pkg::H4_LSB] = 1'b1;
    end
    if (timing_test_control[dtu_pkg::TEST_V5_BIT]) begin
      v_test_inc[dtu_pkg::V5_LSB] = 1'b1;
    end
    if (timing_test_control[dtu_pkg::TEST_V4_BIT]) begin
      v_test_inc[dtu_pkg::V4_LSB] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Character clock
  // ----------------------------------------------------------------
  dtu_char_clock u_char_clock (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .char_en (char_en)
  );

  // ----------------------------------------------------------------
  // Horizontal counter
  // ----------------------------------------------------------------
  assign line_wrap = char_en && (h_cnt == dtu_pkg::H_TOTAL) && !test_read;
  assign h_active  = (h_cnt < dtu_pkg::H_ACTIVE);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      h_cnt <= '0;
    end else if (test_read) begin
      h_cnt <= h_cnt + h_test_inc;
    end else if (line_wrap) begin
      h_cnt <= '0;
    end else if (char_en) begin
      h_cnt <= h_cnt + 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // Vertical counter
  // ----------------------------------------------------------------
  assign line_adv   = line_wrap && (!timing_mode_control[dtu_pkg::MODE_VDOUBLE_BIT] || half_line);
  assign frame_wrap = line_adv && (v_cnt == dtu_pkg::V_TOTAL);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      half_line <= 1'b0;
    end else if (line_wrap) begin
      half_line <= !half_line;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      v_cnt <= '0;
    end else if (test_read) begin
      v_cnt <= v_cnt + v_test_inc;
    end else if (frame_wrap) begin
      v_cnt <= '0;
    end else if (line_adv) begin
      v_cnt <= v_cnt + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Character row scan and underline
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n || frame_wrap) begin
      row_scan <= 5'h00;
    end else if (line_adv) begin
      row_scan <= (row_scan == dtu_pkg::ROW_LAST) ? 5'h00 : row_scan + 5'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      underline_scan <= 1'b0;
    end else begin
      underline_scan <= (row_scan == underline_row_register[dtu_pkg::UL_LOC_MSB:0]);
    end
  end

  // ----------------------------------------------------------------
  // Active display and vertical blanking
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      display_active <= 1'b0;
    end else begin
      display_active <= h_active && (v_cnt <= {2'h0, vertical_active_end});
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vblank <= 1'b0;
    end else if (line_adv && v_cnt[7:0] == vertical_blanking_start) begin
      vblank <= 1'b1;
    end else if (line_adv && v_cnt[7:0] == vertical_blanking_end) begin
      vblank <= 1'b0;
    end
  end

  assign mem_fetch = char_en && h_active && display_active;

  // ----------------------------------------------------------------
  // Fetch address
  // ----------------------------------------------------------------
  dtu_fetch_addr u_fetch_addr (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .char_en    (char_en),
    .h_active   (h_active),
    .line_wrap  (line_wrap),
    .line_adv   (line_adv),
    .frame_wrap (frame_wrap),
    .pitch      (line_pitch),
    .fetch_mode (fetch_mode),
    .step_mode  (step_mode),
    .mem_addr   (mem_addr)
  );

  // ----------------------------------------------------------------
  // Sync generation
  // ----------------------------------------------------------------
  assign sync_en    = timing_mode_control[dtu_pkg::MODE_SYNC_EN_BIT];
  assign h_sync_win = (h_cnt >= dtu_pkg::H_SYNC_START) && (h_cnt < dtu_pkg::H_SYNC_END);
  assign v_sync_win = (v_cnt >= dtu_pkg::V_SYNC_START) && (v_cnt < dtu_pkg::V_SYNC_END);
  assign h_act_lvl  = timing_test_control[dtu_pkg::TEST_FORCE_BIT] || !hsync_neg_sel;
  assign v_act_lvl  = timing_test_control[dtu_pkg::TEST_FORCE_BIT] || !vsync_neg_sel;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hsync <= 1'b0;
    end else if (sync_en && h_sync_win) begin
      hsync <= h_act_lvl;
    end else begin
      hsync <= !h_act_lvl;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vsync <= 1'b0;
    end else if (sync_en && v_sync_win) begin
      vsync <= v_act_lvl;
    end else begin
      vsync <= !v_act_lvl;
    end
  end

endmodule
